// ==== logic/mts_pkg.sv ====
// constants shared by the message-to-shared-line bridge
`default_nettype none
package mts_pkg;
  // frame layout: 4 KB frames, frame index in haddr[15:12]
  localparam int unsigned MTS_FRAME_LSB   = 12;
  localparam int unsigned MTS_FRAME_MSB   = 15;
  localparam logic [3:0]  MTS_CTRL_FRAME  = 4'hf;
  // per-frame register offsets
  localparam logic [11:0] MTS_OFF_RANGE   = 12'h008;
  localparam logic [11:0] MTS_OFF_TRIGGER = 12'h040;
  localparam logic [11:0] MTS_OFF_IDENT   = 12'hfcc;
  // control frame register offsets
  localparam logic [11:0] MTS_OFF_STATUS  = 12'h000;
  localparam logic [11:0] MTS_OFF_MASK    = 12'h004;
  localparam logic [11:0] MTS_OFF_CTRL    = 12'h008;
  // field positions
  localparam int unsigned MTS_LINE_MSB    = 9;
  localparam int unsigned MTS_RBASE_LSB   = 16;
  localparam int unsigned MTS_CTRL_EN     = 0;
  localparam int unsigned MTS_CTRL_SECON  = 1;
  // event bits of status and mask
  localparam int unsigned MTS_EVT_W       = 3;
  localparam int unsigned MTS_EVT_FIRE    = 0;
  localparam int unsigned MTS_EVT_DROP    = 1;
  localparam int unsigned MTS_EVT_SECV    = 2;
  // reset values
  localparam logic [2:0]  MTS_MASK_RST    = 3'h0;
  localparam logic        MTS_EN_RST      = 1'b1;
  // ahb transfer sizes
  localparam logic [2:0]  MTS_HSIZE_HALF  = 3'h1;
  localparam logic [2:0]  MTS_HSIZE_WORD  = 3'h2;
  // identification word: arbitrary value, architecture version field zero
  localparam logic [31:0] MTS_IDENT_VAL   = 32'h0010_0000;
endpackage
`default_nettype wire

// ==== logic/mts_link_if.sv ====
// carrier between bus slave, bridge core and edge generator
`timescale 1ns/10ps
`default_nettype none
interface mts_link_if #(parameter int IDXW = 4);
  logic            wr_stb;
  logic [15:0]     wr_addr;
  logic [2:0]      wr_size;
  logic            wr_nonsec;
  logic [31:0]     wr_data;
  logic [15:0]     rd_addr;
  logic            rd_nonsec;
  logic [31:0]     rd_data;
  logic            fire;
  logic [IDXW-1:0] fire_idx;
  modport bus  (output wr_stb, wr_addr, wr_size, wr_nonsec, wr_data, rd_addr, rd_nonsec, input rd_data);
  modport core (input wr_stb, wr_addr, wr_size, wr_nonsec, wr_data, rd_addr, rd_nonsec, output rd_data,
                output fire, fire_idx);
  modport gen  (input fire, fire_idx);
endinterface
`default_nettype wire

// ==== logic/mts_ahb_slave.sv ====
// ahb-lite slave front end, zero wait states
`timescale 1ns/10ps
`default_nettype none
module mts_ahb_slave
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [15:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hnonsec,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  mts_link_if.bus          lnk
);
  import mts_pkg::*;

  logic        wpend_ff;
  logic [15:0] waddr_ff;
  logic [2:0]  wsize_ff;
  logic        wnsec_ff;
  logic [31:0] rdata_ff;

  wire take   = hsel & htrans[1] & hready;
  wire take_r = take & ~hwrite;

  // read data is sampled at the address phase so hrdata comes from a flop
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wpend_ff <= 1'b0;
      waddr_ff <= 16'h0000;
      wsize_ff <= 3'h0;
      wnsec_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      wpend_ff <= take & hwrite;
      if (take)
      begin
        waddr_ff <= haddr;
        wsize_ff <= hsize;
        wnsec_ff <= hnonsec;
      end
      rdata_ff <= take_r ? lnk.rd_data : 32'h0000_0000;
    end
  end

  assign lnk.wr_stb    = wpend_ff;
  assign lnk.wr_addr   = waddr_ff;
  assign lnk.wr_size   = wsize_ff;
  assign lnk.wr_nonsec = wnsec_ff;
  assign lnk.wr_data   = hwdata;
  assign lnk.rd_addr   = haddr;
  assign lnk.rd_nonsec = hnonsec;
  assign hrdata        = rdata_ff;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
endmodule // mts_ahb_slave
`default_nettype wire

// ==== logic/mts_edge_gen.sv ====
// one-cycle pulse per accepted trigger, with one deferral slot per line
`timescale 1ns/10ps
`default_nettype none
module mts_edge_gen #(
  parameter int NLINES = 40,
  parameter int IDXW   = 6
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  mts_link_if.gen                lnk,
  output var  logic [NLINES-1:0] line_pulse
);
  logic [NLINES-1:0] pulse_ff;
  logic [NLINES-1:0] pend_ff;

  wire [NLINES-1:0] req       = lnk.fire ? (NLINES'(1) << lnk.fire_idx) : '0;
  wire [NLINES-1:0] want      = req | pend_ff;
  // a line pulsed last cycle waits one cycle so the two requests stay two edges
  wire [NLINES-1:0] nxt_pulse = want & ~pulse_ff;
  wire [NLINES-1:0] nxt_pend  = want & pulse_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse_ff <= '0;
      pend_ff  <= '0;
    end
    else
    begin
      pulse_ff <= nxt_pulse;
      pend_ff  <= nxt_pend;
    end
  end

  assign line_pulse = pulse_ff;
endmodule // mts_edge_gen
`default_nettype wire

// ==== logic/mts_msi_bridge.sv ====
// message write to shared interrupt line bridge, top level
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module mts_msi_bridge #(
  parameter int         NUM_NS    = 2,
  parameter int         NS_COUNT  = 16,
  parameter logic [9:0] NS_BASE   = 10'h040,
  parameter bit         SEC_EN    = 1'b1,
  parameter bit         CTRL_SEC  = 1'b1,
  parameter int         SEC_COUNT = 8,
  parameter logic [9:0] SEC_BASE  = 10'h080
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [15:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hnonsec,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [NUM_NS*NS_COUNT+((SEC_EN&&CTRL_SEC)?SEC_COUNT:0)-1:0] line_pulse,
  output var  logic [NUM_NS*NS_COUNT+((SEC_EN&&CTRL_SEC)?SEC_COUNT:0)-1:0] line_secure,
  output var  logic        irq
);
  import mts_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // sizing
  // the secure frame only exists when the controller has security as well
  localparam bit SEC_ON   = SEC_EN && CTRL_SEC;
  localparam int NS_LINES = NUM_NS * NS_COUNT;
  // overlapping ranges would alias two frames onto one line, so the
  // secure frame stays dead unless its lines sit clear of the others
  localparam bit SEC_APART = (int'(SEC_BASE) >= int'(NS_BASE) + NS_LINES) ||
                             (int'(SEC_BASE) + SEC_COUNT <= int'(NS_BASE));
  localparam bit SEC_LIVE  = SEC_ON && SEC_APART;
  localparam int NLINES   = NS_LINES + (SEC_ON ? SEC_COUNT : 0);
  localparam int IDXW     = (NLINES > 1) ? $clog2(NLINES) : 1;
  localparam logic [3:0] SEC_FRAME = 4'(NUM_NS);

  ////////////////////////////////////////////////////////////////////////////////
  // reset release
  // pin asserts at once; the copy lifts two edges after the pin rises
  logic [1:0] rsync_ff;
  wire        rst_n = rsync_ff[1];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rsync_ff <= 2'b00;
    end
    else
    begin
      rsync_ff <= {rsync_ff[0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame helpers
  function automatic logic is_ns(input logic [3:0] f);
    is_ns = (int'(f) < NUM_NS);
  endfunction

  function automatic logic is_sec(input logic [3:0] f);
    is_sec = SEC_LIVE && (f == SEC_FRAME);
  endfunction

  // lowest owned line of a frame; non-secure frames sit back to back
  function automatic logic [9:0] fr_base(input logic [3:0] f);
    if (is_sec(f))
    begin
      fr_base = SEC_BASE;
    end
    else
    begin
      fr_base = NS_BASE + 10'(int'(f) * NS_COUNT);
    end
  endfunction

  function automatic logic [9:0] fr_count(input logic [3:0] f);
    fr_count = is_sec(f) ? 10'(SEC_COUNT) : 10'(NS_COUNT);
  endfunction

  // where the frame's first line sits in the output vector
  function automatic logic [IDXW-1:0] fr_slot(input logic [3:0] f);
    fr_slot = is_sec(f) ? IDXW'(NS_LINES) : IDXW'(int'(f) * NS_COUNT);
  endfunction

  function automatic logic [31:0] range_word(input logic [3:0] f);
    range_word = 32'h0000_0000;
    range_word[MTS_RBASE_LSB +: 10] = fr_base(f);
    range_word[MTS_LINE_MSB:0]      = fr_count(f);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // carrier and leaves
  mts_link_if #(.IDXW(IDXW)) lnk ();

  mts_ahb_slave u_slave
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hnonsec   (hnonsec),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .lnk       (lnk.bus)
  );

  mts_edge_gen #(.NLINES(NLINES), .IDXW(IDXW)) u_edge
  (
    .clk        (clk),
    .rst_n      (rst_n),
    .lnk        (lnk.gen),
    .line_pulse (line_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // control state
  // enable comes up set so triggers work straight after reset
  logic [MTS_EVT_W-1:0] status_ff;
  logic [MTS_EVT_W-1:0] mask_ff;
  logic                 en_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // write decode
  wire [3:0]  w_frame = lnk.wr_addr[MTS_FRAME_MSB:MTS_FRAME_LSB];
  wire [11:0] w_off   = lnk.wr_addr[MTS_FRAME_LSB-1:0];
  wire        w_ns    = is_ns(w_frame);
  wire        w_sec   = is_sec(w_frame);
  wire        w_ctrl  = (w_frame == MTS_CTRL_FRAME);
  wire        w_word  = (lnk.wr_size == MTS_HSIZE_WORD);
  wire        w_secv  = lnk.wr_stb & w_sec & lnk.wr_nonsec;
  wire        w_frok  = w_ns | (w_sec & ~lnk.wr_nonsec);

  // halfword writes are taken only on the low half, word writes always
  wire        w_lowhalf = (lnk.wr_size == MTS_HSIZE_HALF) & ~lnk.wr_addr[1];
  wire        w_size_ok = w_word | w_lowhalf;

  // offset decodes of the write side
  wire        w_at_trig = (w_off == MTS_OFF_TRIGGER);
  wire        w_at_stat = (w_off == MTS_OFF_STATUS);
  wire        w_at_mask = (w_off == MTS_OFF_MASK);
  wire        w_at_ctrl = (w_off == MTS_OFF_CTRL);

  wire        trig_wr = lnk.wr_stb & w_frok & w_at_trig & w_size_ok;
  wire [9:0]  trig_id = lnk.wr_data[MTS_LINE_MSB:0];
  wire [9:0]  w_base  = fr_base(w_frame);
  wire [9:0]  w_cnt   = fr_count(w_frame);
  // widen before the sum so a range ending near the top does not wrap
  wire [10:0] w_end   = {1'b0, w_base} + {1'b0, w_cnt};
  wire        in_rng  = (trig_id >= w_base) & ({1'b0, trig_id} < w_end);

  // disabled bridge drops in-range triggers silently; an out-of-range one sets the drop event
  wire        fire    = trig_wr & in_rng & en_ff;
  wire        drop    = trig_wr & ~in_rng;
  wire [9:0]  rel_id  = trig_id - w_base;

  // output slot of the line inside the frame's block of outputs
  wire [IDXW-1:0] w_slot = fr_slot(w_frame) + IDXW'(rel_id);

  assign lnk.fire     = fire;
  assign lnk.fire_idx = w_slot;

  wire        stat_wr = lnk.wr_stb & w_ctrl & w_word & w_at_stat;
  wire        mask_wr = lnk.wr_stb & w_ctrl & w_word & w_at_mask;
  wire        ctrl_wr = lnk.wr_stb & w_ctrl & w_word & w_at_ctrl;

  ////////////////////////////////////////////////////////////////////////////////
  // events and interrupt
  wire [MTS_EVT_W-1:0] evt;
  assign evt[MTS_EVT_FIRE] = fire;
  assign evt[MTS_EVT_DROP] = drop;
  assign evt[MTS_EVT_SECV] = w_secv;

  // write one to clear, word writes only
  wire [MTS_EVT_W-1:0] clr        = stat_wr ? lnk.wr_data[MTS_EVT_W-1:0] : '0;
  // a new event in the clearing cycle survives the clear
  wire [MTS_EVT_W-1:0] nxt_status = (status_ff & ~clr) | evt;
  wire [MTS_EVT_W-1:0] nxt_mask   = mask_wr ? lnk.wr_data[MTS_EVT_W-1:0] : mask_ff;
  wire                 nxt_en     = ctrl_wr ? lnk.wr_data[MTS_CTRL_EN] : en_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_ff <= '0;
    end
    else
    begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_ff <= MTS_MASK_RST;
    end
    else
    begin
      mask_ff <= nxt_mask;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_ff <= MTS_EN_RST;
    end
    else
    begin
      en_ff <= nxt_en;
    end
  end

  assign irq = |(status_ff & mask_ff);

  ////////////////////////////////////////////////////////////////////////////////
  // read decode
  wire [3:0]  r_frame = lnk.rd_addr[MTS_FRAME_MSB:MTS_FRAME_LSB];
  wire [11:0] r_off   = lnk.rd_addr[MTS_FRAME_LSB-1:0];
  // non-secure reads of the secure frame see zero
  wire        r_frok  = is_ns(r_frame) | (is_sec(r_frame) & ~lnk.rd_nonsec);
  wire        r_ctrl  = (r_frame == MTS_CTRL_FRAME);

  wire [31:0] r_range = range_word(r_frame);
  wire [31:0] r_ctrlw = {30'h0000_0000, SEC_LIVE, en_ff};
  wire [31:0] r_stat  = {{(32-MTS_EVT_W){1'b0}}, status_ff};
  wire [31:0] r_mask  = {{(32-MTS_EVT_W){1'b0}}, mask_ff};

  // offset decodes of the read side
  wire        r_at_range = (r_off == MTS_OFF_RANGE);
  wire        r_at_ident = (r_off == MTS_OFF_IDENT);
  wire        r_at_stat  = (r_off == MTS_OFF_STATUS);
  wire        r_at_mask  = (r_off == MTS_OFF_MASK);
  wire        r_at_ctrl  = (r_off == MTS_OFF_CTRL);

  // trigger register is write-only and reads as zero
  wire [31:0] r_frame_val = r_at_range ? r_range :
                            r_at_ident ? MTS_IDENT_VAL : 32'h0000_0000;
  wire [31:0] r_ctrl_val  = r_at_stat ? r_stat :
                            r_at_mask ? r_mask :
                            r_at_ctrl ? r_ctrlw : 32'h0000_0000;

  assign lnk.rd_data = r_frok ? r_frame_val :
                       r_ctrl ? r_ctrl_val : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // per-line security marking for the controller's group setup
  // without the secure frame every line is marked non-secure
  genvar gi;
  generate
    for (gi = 0; gi < NLINES; gi++)
    begin : g_sec
      assign line_secure[gi] = SEC_ON && (gi >= NS_LINES);
    end
  endgenerate

  // lines are private outputs; nothing else may be ored onto them upstream
  // of the controller; an overlapping secure range leaves that frame dead
endmodule // mts_msi_bridge
`default_nettype wire

// ==== tb/mts_msi_bridge_assertions.sv ====
// concurrent checks on the bridge top ports
`timescale 1ns/10ps
`default_nettype none
module mts_msi_bridge_assertions
  import mts_pkg::*;
#(
  parameter int         NUM_NS    = 2,
  parameter int         NS_COUNT  = 16,
  parameter logic [9:0] NS_BASE   = 10'h040,
  parameter int         SEC_COUNT = 8,
  parameter logic [9:0] SEC_BASE  = 10'h080,
  localparam int        NL        = NUM_NS*NS_COUNT+SEC_COUNT
)
(
  input wire logic          clk,
  input wire logic          resetn,
  input wire logic          hsel,
  input wire logic [15:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic [2:0]    hsize,
  input wire logic          hnonsec,
  input wire logic          hready,
  input wire logic [31:0]   hwdata,
  input wire logic [31:0]   hrdata,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic [NL-1:0] line_pulse,
  input wire logic [NL-1:0] line_secure,
  input wire logic          irq
);
  ////////////////////////////////////////////////////////////////////////
  wire        take = hsel & htrans[1] & hready;
  wire [3:0]  frm  = haddr[15:12];
  wire        sec  = frm == 4'(NUM_NS);
  wire        vis  = frm < 4'(NUM_NS) || (sec && !hnonsec);
  wire [9:0]  lo   = sec ? SEC_BASE : NS_BASE + 10'(frm*NS_COUNT);
  wire [9:0]  cnt  = sec ? 10'(SEC_COUNT) : 10'(NS_COUNT);
  wire        szok = hsize == MTS_HSIZE_WORD || (hsize == MTS_HSIZE_HALF && !haddr[1]);
  wire        trg  = take && hwrite && vis && haddr[11:0] == MTS_OFF_TRIGGER && szok;
  wire [31:0] rv   = !vis ? 32'h0 : haddr[11:0] == MTS_OFF_RANGE ? {6'h0, lo, 6'h0, cnt} :
                     haddr[11:0] == MTS_OFF_IDENT ? MTS_IDENT_VAL : 32'h0;
  logic          trg_ff, rd_ff, ctl_ff, wd_ff, en_ff, en_d1, ok_d1, ok_d2;
  logic [9:0]    lo_ff, cnt_ff, slot_ff, ix_d1, ix_d2;
  logic [31:0]   rv_ff;
  logic [NL-1:0] pl_d1;
  // disabled or out-of-range triggers must not count as a cause
  wire ok = trg_ff && en_ff && hwdata[9:0] >= lo_ff && hwdata[9:0] < lo_ff + cnt_ff;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      {trg_ff, rd_ff, ctl_ff, wd_ff, ok_d1, ok_d2, pl_d1} <= '0;
      en_ff <= MTS_EN_RST;
      en_d1 <= MTS_EN_RST;
    end
    else
    begin
      trg_ff <= trg;
      rd_ff <= take && !hwrite && frm != MTS_CTRL_FRAME && hsize == MTS_HSIZE_WORD;
      ctl_ff <= take && hwrite && frm == MTS_CTRL_FRAME && haddr[11:0] == MTS_OFF_CTRL;
      wd_ff <= take && hwrite;
      en_ff <= ctl_ff ? hwdata[MTS_CTRL_EN] : en_ff;
      en_d1 <= en_ff;
      ok_d1 <= ok;
      ok_d2 <= ok_d1;
      pl_d1 <= line_pulse;
    end
  always_ff @(posedge clk)
  begin
    lo_ff <= lo;
    cnt_ff <= cnt;
    slot_ff <= 10'(frm*NS_COUNT);
    rv_ff <= rv;
    ix_d1 <= slot_ff + hwdata[9:0] - lo_ff;
    ix_d2 <= ix_d1;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_pulse_after_trig; ok_d2 |-> line_pulse[ix_d2] || pl_d1[ix_d2]; endproperty
  a_pulse_after_trig: assert property (p_pulse_after_trig) else $error("trigger gave no pulse");
  property p_one_cycle; (line_pulse & pl_d1) == '0; endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("pulse longer than one cycle");
  property p_no_stray; line_pulse != '0 |-> ok_d1 || ok_d2; endproperty
  a_no_stray: assert property (p_no_stray) else $error("pulse without accepted trigger");
  property p_read_val; rd_ff |-> hrdata == rv_ff; endproperty
  a_read_val: assert property (p_read_val) else $error("frame read value wrong");
  property p_sec_lines; line_secure == {{SEC_COUNT{1'b1}}, {(NUM_NS*NS_COUNT){1'b0}}}; endproperty
  a_sec_lines: assert property (p_sec_lines) else $error("secure line map wrong");
  property p_zero_wait; hreadyout && !hresp; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("wait state or error response");
  property p_irq_cause; $rose(irq) |-> $past(wd_ff); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without a write");
  property p_off_quiet; !en_ff && !en_d1 |-> line_pulse == '0; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("pulse while disabled");
  c_pulse: cover property (ok_d2);
  c_read: cover property (rd_ff && rv_ff != 32'h0);
  c_irq: cover property ($rose(irq));
endmodule // mts_msi_bridge_assertions
`default_nettype wire

// ==== tb/mts_gic_model.sv ====
// shared interrupt inputs of the interrupt controller, edge counting
`timescale 1ns/10ps
`default_nettype none
module mts_gic_model #(
  parameter int NL = 40
)
(
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic [NL-1:0] line_pulse,
  input  wire logic [NL-1:0] line_secure,
  output var  logic [NL-1:0] grp0,
  output var  int unsigned   edges [NL]
);
  logic [NL-1:0] prev_ff;
  // secure frame lines group 0, the rest group 1
  // group 0 lines may later be handed to non-secure software to manage
  assign grp0 = line_secure;
  // lines set up edge-triggered: a level held high counts once only
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      prev_ff <= '0;
      foreach (edges[i]) edges[i] <= 0;
    end
    else
    begin
      prev_ff <= line_pulse;
      foreach (edges[i]) edges[i] <= edges[i] + 32'(line_pulse[i] & !prev_ff[i]);
    end
endmodule // mts_gic_model
`default_nettype wire

// ==== tb/tb_mts_msi_bridge.sv ====
// self-checking bench for the message-to-shared-line bridge
`timescale 1ns/10ps
`default_nettype none
module tb_mts_msi_bridge;
  import mts_pkg::*;
  localparam int NL = 40;
  logic          clk = 1'b0;
  logic          resetn = 1'b0;
  logic          hsel = 1'b0;
  logic          hwrite = 1'b0;
  logic          hnonsec = 1'b0;
  logic [15:0]   haddr = '0;
  logic [1:0]    htrans = '0;
  logic [2:0]    hsize = '0;
  logic [31:0]   hwdata = '0;
  logic [31:0]   r;
  wire  [31:0]   hrdata;
  wire           hreadyout, hresp, irq;
  wire  [NL-1:0] line_pulse, line_secure, grp0;
  int unsigned   edges [NL];
  int unsigned   exp_e [NL];
  int            num_errors = 0;
  int            checked = 0;
  always #20 clk = ~clk;
  mts_msi_bridge mts_msi_bridge_inst (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hnonsec(hnonsec), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .line_pulse(line_pulse), .line_secure(line_secure), .irq(irq));
  mts_gic_model mts_gic_model_inst (.clk(clk), .resetn(resetn), .line_pulse(line_pulse),
    .line_secure(line_secure), .grp0(grp0), .edges(edges));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d of %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ready and read data are taken at the rising edge that ends the phase
  task automatic wait_rdy;
    logic rdy;
    int   n;
    n = 0;
    do
    begin
      @(posedge clk);
      rdy = hreadyout;
      r = hrdata;
      n++;
      if (n > 20)
      begin
        num_errors++;
        report_and_stop;
      end
    end while (rdy !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [2:0] sz, input logic ns, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    hnonsec <= ns;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
  endtask
  task automatic rd(input logic [15:0] a, input logic ns, input logic [31:0] want);
    bus(1'b0, a, MTS_HSIZE_WORD, ns, 32'h0);
    check(r, want);
  endtask
  task automatic lines;
    repeat (3) @(posedge clk);
    foreach (exp_e[i]) check(edges[i], exp_e[i]);
  endtask
  task automatic chk_irq(input logic want);
    @(negedge clk);
    check(32'(irq), 32'(want));
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic s_regs;
    rd(16'h0008, 1'b0, {6'h0, 10'h040, 6'h0, 10'd16});
    rd(16'h1008, 1'b0, {6'h0, 10'h050, 6'h0, 10'd16});
    rd(16'h2008, 1'b0, {6'h0, 10'h080, 6'h0, 10'd8});
    rd(16'h2008, 1'b1, 32'h0);
    rd(16'h0fcc, 1'b0, MTS_IDENT_VAL);
    rd(16'h0040, 1'b0, 32'h0);
    rd(16'h0010, 1'b0, 32'h0);
    rd(16'hf008, 1'b0, 32'h3);
    check(32'(line_secure >> 8), 32'hff00_0000);
    check(32'(grp0 >> 8), 32'hff00_0000);
  endtask
  task automatic s_trigger;
    logic [9:0] lo;
    int         n;
    for (int f = 0; f < 3; f++)
      for (int k = 0; k < 2; k++)
      begin
        lo = f < 2 ? 10'(10'h040 + 16 * f) : 10'h080;
        n = f < 2 ? 16 : 8;
        // upper data bits set on purpose: only the low ten pick the line
        bus(1'b1, 16'(f * 16'h1000 + 16'h0040), MTS_HSIZE_WORD, 1'b0, 32'hffff_fc00 | 32'(lo + k * (n - 1)));
        exp_e[f * 16 + k * (n - 1)]++;
      end
    bus(1'b1, 16'h0040, MTS_HSIZE_HALF, 1'b0, 32'h1234_0045);
    exp_e[5]++;
    bus(1'b1, 16'h0040, MTS_HSIZE_WORD, 1'b0, 32'h46);
    bus(1'b1, 16'h0040, MTS_HSIZE_WORD, 1'b0, 32'h46);
    exp_e[6] += 2;
    lines;
  endtask
  task automatic s_reject;
    bus(1'b1, 16'h0040, MTS_HSIZE_WORD, 1'b0, 32'h50);
    bus(1'b1, 16'h2040, MTS_HSIZE_WORD, 1'b1, 32'h80);
    lines;
    rd(16'hf000, 1'b0, 32'h7);
    bus(1'b1, 16'hf000, MTS_HSIZE_WORD, 1'b0, 32'h7);
    rd(16'hf000, 1'b0, 32'h0);
  endtask
  task automatic s_irq;
    chk_irq(1'b0);
    bus(1'b1, 16'h0040, MTS_HSIZE_WORD, 1'b0, 32'h47);
    exp_e[7]++;
    chk_irq(1'b0);
    bus(1'b1, 16'hf004, MTS_HSIZE_WORD, 1'b0, 32'h1);
    chk_irq(1'b1);
    bus(1'b1, 16'hf000, MTS_HSIZE_WORD, 1'b0, 32'h1);
    chk_irq(1'b0);
    bus(1'b1, 16'hf004, MTS_HSIZE_WORD, 1'b0, 32'h0);
    lines;
  endtask
  task automatic s_enable;
    bus(1'b1, 16'hf008, MTS_HSIZE_WORD, 1'b0, 32'h0);
    rd(16'hf008, 1'b0, 32'h2);
    bus(1'b1, 16'h0040, MTS_HSIZE_WORD, 1'b0, 32'h40);
    lines;
    bus(1'b1, 16'hf008, MTS_HSIZE_WORD, 1'b0, 32'h1);
    rd(16'hf000, 1'b0, 32'h0);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    s_regs;
    s_trigger;
    s_reject;
    s_irq;
    s_enable;
    report_and_stop;
  end
endmodule // tb_mts_msi_bridge
bind mts_msi_bridge mts_msi_bridge_assertions #(.NUM_NS(NUM_NS), .NS_COUNT(NS_COUNT), .NS_BASE(NS_BASE),
  .SEC_COUNT(SEC_COUNT), .SEC_BASE(SEC_BASE)) mts_msi_bridge_assertions_inst (.clk(clk), .resetn(resetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hnonsec(hnonsec), .hready(hready),
  .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .line_pulse(line_pulse),
  .line_secure(line_secure), .irq(irq));
`default_nettype wire
